// ---- src/cfa_defines.svh ----
// Constants of the CAN frame and arbitration engine.
`ifndef CFA_DEFINES_SVH
`define CFA_DEFINES_SVH

// ==========================================================================
// Field widths
`define CFA_ID_W          29
`define CFA_DATA_W        64
`define CFA_HDR_W         38
`define CFA_CRC_W         15

// ==========================================================================
// Bit indices inside the header field (count of bits after start of frame; CFA_RTR_POS counts back from the last header bit)
`define CFA_IDE_IDX       7'h0C
`define CFA_ARB_STD_LAST  7'h0C
`define CFA_ARB_EXT_LAST  7'h1F
`define CFA_STD_HDR_LAST  7'h11
`define CFA_EXT_HDR_LAST  7'h25
`define CFA_RTR_POS       6

// ==========================================================================
// Field lengths, given as last index of a zero based count; CFA_STUFF_LEN is the run length itself
`define CFA_CRC_LAST      7'h0E
`define CFA_EOF_LAST      7'h06
`define CFA_INTER_LAST    7'h02
`define CFA_EFLAG_LAST    7'h05
`define CFA_EDELIM_LAST   7'h07
`define CFA_STUFF_LEN     3'h5

// ==========================================================================
// Coding constants
`define CFA_CRC_POLY      15'h4599
`define CFA_MAX_DLC       4'h8
`define CFA_FULL_DATA     7'h40
`define CFA_FIFO_DEPTH    8

`endif

// ---- src/cfa_pkg.sv ----
// Types shared by the CAN frame and arbitration engine.
`include "cfa_defines.svh"

package cfa_pkg;

  // ========================================================================
  // One message as exchanged with the local host.
  typedef struct packed {
    logic                   ext;
    logic                   rtr;
    logic [`CFA_ID_W-1:0]   id;
    logic [3:0]             dlc;
    logic [`CFA_DATA_W-1:0] data;
  } cfa_msg_s;

  // ========================================================================
  // One-cycle event flags reported to the local host.
  typedef struct packed {
    logic arb_lost;
    logic tx_done;
    logic rx_done;
    logic bus_err;
    logic rx_overrun;
  } cfa_status_s;

  // ========================================================================
  // Frame engine states, one-hot.
  typedef enum logic [11:0] {
    ST_IDLE    = 12'h001,
    ST_SOF     = 12'h002,
    ST_HDR     = 12'h004,
    ST_DATA    = 12'h008,
    ST_CRC     = 12'h010,
    ST_CRCDEL  = 12'h020,
    ST_ACK     = 12'h040,
    ST_ACKDEL  = 12'h080,
    ST_EOF     = 12'h100,
    ST_INTER   = 12'h200,
    ST_ERRFLAG = 12'h400,
    ST_ERRDEL  = 12'h800
  } cfa_state_e;

endpackage

// ---- src/cfa_fifo.sv ----
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns

module cfa_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  // Handshakes on each side; full and empty follow the fill count.
  assign in_ready_o  = (cnt_reg != (AW+1)'(D));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage is written at the write index only.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// ---- src/cfa_engine.sv ----
// CAN frame builder, parser and bitwise arbiter working on sampled bits.
//
// Functional notes
// - Lower identifier wins bus access.
// - Transmit only after bus is idle.
// - Non-sender receives from start-of-frame bit.
// - Filter received identifier, store or discard.
// - Send identifier MSB first, sample each bit.
// - Recessive sent, dominant seen: lose, receive.
// - Keep lost message, retry when idle.
// - Support 11 and 29 bit identifiers.
// - Frame starts with one dominant bit.
// - Standard arbitration: 11-bit id plus RTR.
// - Standard control: IDE, r0 dominant, DLC.
// - DLC gives zero to eight data bytes.
// - Send 15-bit CRC then recessive delimiter.
// - Sender recessive ack; good receivers dominant.
// - Acknowledge delimiter recessive, never dominant.
// - Seven recessive end-of-frame bits.
// - Three recessive intermission bits between frames.
// - Extended arbitration: base, SRR, IDE, ext, RTR.
// - Extended control: two reserved dominant, DLC.
// - Remote frame: RTR recessive, no data.
// - Answer matching remote request with data frame.
// - Error: flag by status, eight recessive delimiter.
// - Error-active flag is six dominant bits.
// - Error-passive flag is six recessive bits.
// - Stuff after five equal bits, remove on receive.
`timescale 1ns/1ns
`include "cfa_defines.svh"

module cfa_engine #(
  parameter int FIFO_DEPTH = `CFA_FIFO_DEPTH
) (
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   bit_tick_i,
  input  wire logic                   bus_rx_i,
  output logic                        bus_tx_o,
  input  wire logic                   error_passive_i,
  input  wire logic                   tx_req_i,
  input  wire cfa_pkg::cfa_msg_s      tx_msg_i,
  output logic                        tx_busy_o,
  input  wire logic                   resp_en_i,
  input  wire cfa_pkg::cfa_msg_s      resp_msg_i,
  input  wire logic [`CFA_ID_W-1:0]   acc_id_i,
  input  wire logic [`CFA_ID_W-1:0]   acc_mask_i,
  input  wire logic                   acc_ext_i,
  output logic                        rx_valid_o,
  input  wire logic                   rx_ready_i,
  output cfa_pkg::cfa_msg_s           rx_msg_o,
  output cfa_pkg::cfa_status_s        status_o
);
  import cfa_pkg::*;

  // ========================================================================
  // Helper functions
  // One CRC step on a destuffed bit.
  function automatic logic [`CFA_CRC_W-1:0] crc_step(input logic [`CFA_CRC_W-1:0] c,
                                                     input logic b);
    crc_step = {c[`CFA_CRC_W-2:0], 1'b0} ^ ((b ^ c[`CFA_CRC_W-1]) ? `CFA_CRC_POLY : 15'h0);
  endfunction

  // Number of data bits carried by a frame.
  function automatic logic [6:0] data_bits(input logic [3:0] dlc, input logic rtr);
    if (rtr) begin
      data_bits = 7'h00;
    end else if (dlc > `CFA_MAX_DLC) begin
      data_bits = `CFA_FULL_DATA;
    end else begin
      data_bits = {dlc, 3'b000};
    end
  endfunction

  // Header bits after the start bit, left aligned, first bit sent at the top.
  function automatic logic [`CFA_HDR_W-1:0] hdr_build(input cfa_msg_s m);
    if (m.ext) begin
      hdr_build = {m.id[28:18], 1'b1, 1'b1, m.id[17:0], m.rtr, 2'b00, m.dlc};
    end else begin
      hdr_build = {m.id[10:0], m.rtr, 1'b0, 1'b0, m.dlc, 20'h0_0000};
    end
  endfunction

  // ========================================================================
  // Engine state
  cfa_state_e             state_reg, state_next;
  logic [6:0]             cnt_reg, cnt_next;
  logic [`CFA_HDR_W-1:0]  hdr_reg, hdr_next;
  logic [`CFA_DATA_W-1:0] data_reg, data_next;
  logic [`CFA_CRC_W-1:0]  crc_reg, crc_next;
  logic [`CFA_CRC_W-1:0]  crcsh_reg, crcsh_next;
  logic [2:0]             same_reg, same_next;
  logic                   last_reg, last_next;
  logic                   txing_reg, txing_next;
  logic                   ext_reg, ext_next;
  logic [6:0]             dbits_reg, dbits_next;
  logic                   crcok_reg, crcok_next;
  logic                   acked_reg, acked_next;
  logic                   tx_reg, tx_next;
  logic                   err_c, ev_lost, ev_txok, ev_rxok;
  logic                   region, arb_win, b;

  // Pending transmit, received holding slot and status.
  logic                   pend_reg;
  cfa_msg_s               pend_msg_reg;
  logic                   hold_vld_reg;
  cfa_msg_s               hold_msg_reg;
  logic                   hold_rdy;
  cfa_msg_s               rx_msg;
  logic                   accept, remote_hit;
  cfa_status_s            status_reg;

  // Stuffing covers start bit up to the CRC delimiter; arbitration covers id, SRR, IDE, RTR.
  assign b       = bus_rx_i;
  assign region  = (state_reg == ST_SOF) || (state_reg == ST_HDR) ||
                   (state_reg == ST_DATA) || (state_reg == ST_CRC) || (state_reg == ST_CRCDEL);
  assign arb_win = (state_reg == ST_HDR) &&
                   ((cnt_reg <= `CFA_ARB_STD_LAST) ||
                    (ext_reg && (cnt_reg <= `CFA_ARB_EXT_LAST)));

  // ========================================================================
  // Bit processing at each sample point.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    hdr_next   = hdr_reg;
    data_next  = data_reg;
    crc_next   = crc_reg;
    crcsh_next = crcsh_reg;
    same_next  = same_reg;
    last_next  = last_reg;
    txing_next = txing_reg;
    ext_next   = ext_reg;
    dbits_next = dbits_reg;
    crcok_next = crcok_reg;
    acked_next = acked_reg;
    err_c      = 1'b0;
    ev_lost    = 1'b0;
    ev_txok    = 1'b0;
    ev_rxok    = 1'b0;
    if (bit_tick_i) begin
      // Read back what was driven; a lost recessive bit hands over to receive.
      if (txing_reg && (tx_reg != b)) begin
        if (arb_win && tx_reg) begin
          txing_next = 1'b0;
          ev_lost    = 1'b1;
        end else if (state_reg != ST_ACK) begin
          err_c = 1'b1;
        end
      end
      if (region && (same_reg == `CFA_STUFF_LEN)) begin
        // Stuff bit: must differ, carries no payload and no CRC.
        if (b == last_reg) begin
          err_c = 1'b1;
        end
        same_next = 3'h1;
        last_next = b;
      end else begin
        if (region) begin
          same_next = (b == last_reg) ? same_reg + 3'h1 : 3'h1;
          last_next = b;
        end
        unique case (state_reg)
          ST_IDLE: begin
            if (!b) begin
              // Someone else sent a start bit.
              state_next = ST_HDR;
              cnt_next   = 7'h00;
              txing_next = 1'b0;
              same_next  = 3'h1;
              last_next  = 1'b0;
              crc_next   = '0;
            end else if (pend_reg) begin
              // Bus idle and a message waits: next bit is our start bit.
              state_next = ST_SOF;
              txing_next = 1'b1;
              hdr_next   = hdr_build(pend_msg_reg);
              data_next  = pend_msg_reg.data;
              crc_next   = '0;
              same_next  = 3'h0;
              last_next  = 1'b1;
            end
          end
          ST_SOF: begin
            state_next = ST_HDR;
            cnt_next   = 7'h00;
            crc_next   = crc_step(crc_reg, b);
          end
          ST_HDR: begin
            hdr_next = {hdr_reg[`CFA_HDR_W-2:0], b};
            crc_next = crc_step(crc_reg, b);
            cnt_next = cnt_reg + 7'h01;
            if (cnt_reg == `CFA_IDE_IDX) begin
              ext_next = b;
            end
            if (cnt_reg == (ext_reg ? `CFA_EXT_HDR_LAST : `CFA_STD_HDR_LAST)) begin
              dbits_next = data_bits(hdr_next[3:0], hdr_next[`CFA_RTR_POS]);
              cnt_next   = 7'h00;
              if (data_bits(hdr_next[3:0], hdr_next[`CFA_RTR_POS]) == 7'h00) begin
                state_next = ST_CRC;
                crcsh_next = crc_next;
              end else begin
                state_next = ST_DATA;
              end
            end
          end
          ST_DATA: begin
            data_next = {data_reg[`CFA_DATA_W-2:0], b};
            crc_next  = crc_step(crc_reg, b);
            cnt_next  = cnt_reg + 7'h01;
            if ((cnt_reg + 7'h01) == dbits_reg) begin
              state_next = ST_CRC;
              cnt_next   = 7'h00;
              crcsh_next = crc_next;
            end
          end
          ST_CRC: begin
            crcsh_next = {crcsh_reg[`CFA_CRC_W-2:0], b};
            cnt_next   = cnt_reg + 7'h01;
            if (cnt_reg == `CFA_CRC_LAST) begin
              crcok_next = ({crcsh_reg[`CFA_CRC_W-2:0], b} == crc_reg);
              state_next = ST_CRCDEL;
            end
          end
          ST_CRCDEL: begin
            err_c      = err_c || !b;
            state_next = ST_ACK;
          end
          ST_ACK: begin
            acked_next = !b;
            state_next = ST_ACKDEL;
          end
          ST_ACKDEL: begin
            err_c      = err_c || !b;
            state_next = ST_EOF;
            cnt_next   = 7'h00;
          end
          ST_EOF: begin
            err_c    = err_c || !b;
            cnt_next = cnt_reg + 7'h01;
            if (cnt_reg == `CFA_EOF_LAST) begin
              state_next = ST_INTER;
              cnt_next   = 7'h00;
              txing_next = 1'b0;
              if (txing_reg) begin
                ev_txok = acked_reg;
              end else begin
                ev_rxok = crcok_reg;
              end
            end
          end
          ST_INTER: begin
            cnt_next = cnt_reg + 7'h01;
            if (cnt_reg == `CFA_INTER_LAST) begin
              state_next = ST_IDLE;
            end
          end
          ST_ERRFLAG: begin
            cnt_next = cnt_reg + 7'h01;
            if (cnt_reg == `CFA_EFLAG_LAST) begin
              state_next = ST_ERRDEL;
              cnt_next   = 7'h00;
            end
          end
          ST_ERRDEL: begin
            // Count recessive bits; flags of other nodes restart the count.
            cnt_next = b ? cnt_reg + 7'h01 : 7'h00;
            if (b && (cnt_reg == `CFA_EDELIM_LAST)) begin
              state_next = ST_INTER;
              cnt_next   = 7'h00;
            end
          end
        endcase
      end
      if (err_c) begin
        state_next = ST_ERRFLAG;
        cnt_next   = 7'h00;
        txing_next = 1'b0;
      end
    end
  end

  // ========================================================================
  // Level to drive for the next bit time.
  always_comb begin
    tx_next = 1'b1;
    if (txing_next && (same_next == `CFA_STUFF_LEN) &&
        ((state_next == ST_HDR) || (state_next == ST_DATA) ||
         (state_next == ST_CRC) || (state_next == ST_CRCDEL))) begin
      tx_next = !last_next;
    end else begin
      unique case (state_next)
        ST_SOF:     tx_next = 1'b0;
        ST_HDR:     tx_next = txing_next ? hdr_next[`CFA_HDR_W-1] : 1'b1;
        ST_DATA:    tx_next = txing_next ? data_next[`CFA_DATA_W-1] : 1'b1;
        ST_CRC:     tx_next = txing_next ? crcsh_next[`CFA_CRC_W-1] : 1'b1;
        ST_ACK:     tx_next = txing_next || !crcok_next;
        ST_ERRFLAG: tx_next = error_passive_i;
        default:    tx_next = 1'b1;
      endcase
    end
  end

  // ========================================================================
  // Engine registers; reset waits out an intermission before joining.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_INTER;
      cnt_reg   <= 7'h00;
      hdr_reg   <= '0;
      data_reg  <= '0;
      crc_reg   <= '0;
      crcsh_reg <= '0;
      same_reg  <= 3'h0;
      last_reg  <= 1'b1;
      txing_reg <= 1'b0;
      ext_reg   <= 1'b0;
      dbits_reg <= 7'h00;
      crcok_reg <= 1'b0;
      acked_reg <= 1'b0;
      tx_reg    <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      hdr_reg   <= hdr_next;
      data_reg  <= data_next;
      crc_reg   <= crc_next;
      crcsh_reg <= crcsh_next;
      same_reg  <= same_next;
      last_reg  <= last_next;
      txing_reg <= txing_next;
      ext_reg   <= ext_next;
      dbits_reg <= dbits_next;
      crcok_reg <= crcok_next;
      acked_reg <= acked_next;
      tx_reg    <= bit_tick_i ? tx_next : tx_reg;
    end
  end

  // ========================================================================
  // Received message, acceptance and remote request match.
  always_comb begin
    rx_msg.ext  = ext_reg;
    rx_msg.rtr  = hdr_reg[`CFA_RTR_POS];
    rx_msg.dlc  = hdr_reg[3:0];
    rx_msg.id   = ext_reg ? {hdr_reg[37:27], hdr_reg[24:7]} : {18'h0_0000, hdr_reg[17:7]};
    rx_msg.data = data_reg << (`CFA_FULL_DATA - dbits_reg);
  end

  assign accept     = ev_rxok && (rx_msg.ext == acc_ext_i) &&
                      (((rx_msg.id ^ acc_id_i) & acc_mask_i) == '0);
  assign remote_hit = ev_rxok && rx_msg.rtr && resp_en_i &&
                      (rx_msg.ext == resp_msg_i.ext) && (rx_msg.id == resp_msg_i.id);

  // ========================================================================
  // Pending message stays until sent with acknowledge.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_reg     <= 1'b0;
      pend_msg_reg <= '0;
    end else if (ev_txok) begin
      pend_reg <= 1'b0;
    end else if (!pend_reg && tx_req_i) begin
      pend_reg     <= 1'b1;
      pend_msg_reg <= tx_msg_i;
    end else if (!pend_reg && remote_hit) begin
      pend_reg         <= 1'b1;
      pend_msg_reg     <= resp_msg_i;
      pend_msg_reg.rtr <= 1'b0;
    end
  end

  // ========================================================================
  // Holding slot in front of the FIFO; a message finding it busy is lost.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_vld_reg <= 1'b0;
      hold_msg_reg <= '0;
    end else if (accept && (!hold_vld_reg || hold_rdy)) begin
      hold_vld_reg <= 1'b1;
      hold_msg_reg <= rx_msg;
    end else if (hold_rdy) begin
      hold_vld_reg <= 1'b0;
    end
  end

  // Event flags, one cycle each.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg <= '0;
    end else begin
      status_reg.arb_lost   <= ev_lost;
      status_reg.tx_done    <= ev_txok;
      status_reg.rx_done    <= ev_rxok;
      status_reg.bus_err    <= err_c;
      status_reg.rx_overrun <= accept && hold_vld_reg && !hold_rdy;
    end
  end

  cfa_fifo #(
    .W ($bits(cfa_msg_s)),
    .D (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (mclk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (hold_vld_reg),
    .in_ready_o  (hold_rdy),
    .in_data_i   (hold_msg_reg),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_msg_o)
  );

  assign bus_tx_o  = tx_reg;
  assign tx_busy_o = pend_reg;
  assign status_o  = status_reg;

endmodule

// ---- tb/cfa_engine_asserts.sv ----
// Concurrent checks of the CAN frame engine at its ports.
`timescale 1ns/1ns
module cfa_engine_asserts (
  input wire logic                 mclk_i,
  input wire logic                 rst_n_i,
  input wire logic                 bit_tick_i,
  input wire logic                 bus_rx_i,
  input wire logic                 bus_tx_o,
  input wire logic                 error_passive_i,
  input wire logic                 tx_req_i,
  input wire logic                 tx_busy_o,
  input wire cfa_pkg::cfa_status_s status_o
);
  import cfa_pkg::*;
  logic [2:0] tcnt;
  logic [3:0] trun;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================================
  // Ticks since reset, and recessive ticks in a row sent by the engine.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tcnt <= 3'h0;
      trun <= 4'h0;
    end else if (bit_tick_i) begin
      tcnt <= (tcnt == 3'h7) ? tcnt : tcnt + 3'h1;
      trun <= !bus_tx_o ? 4'h0 : (trun == 4'hf) ? trun : trun + 4'h1;
    end
  end
  // ==========================================================================
  // Relations between the line, the host port and the status pulses.
  a_tx_on_tick: assert property ($changed(bus_tx_o) |-> $past(bit_tick_i))
    else $error("line output moved without a bit tick");
  a_busy_on_req: assert property (!tx_busy_o && tx_req_i |=> tx_busy_o)
    else $error("request not taken");
  a_done_ends_busy: assert property (status_o.tx_done |-> !tx_busy_o && $past(tx_busy_o))
    else $error("done pulse without end of pending message");
  a_lost_on_clash: assert property (status_o.arb_lost |->
    $past(bit_tick_i) && $past(bus_tx_o) && !$past(bus_rx_i))
    else $error("lost flag without recessive sent and dominant read");
  a_lost_goes_quiet: assert property (status_o.arb_lost |-> bus_tx_o [*4])
    else $error("line driven after lost arbitration");
  a_lost_keeps_msg: assert property (status_o.arb_lost |-> tx_busy_o)
    else $error("message dropped after lost arbitration");
  a_err_flag_dom: assert property (status_o.bus_err && !error_passive_i |->
    ##[0:4] !bus_tx_o)
    else $error("no dominant error flag");
  a_sof_after_gap: assert property ($fell(bus_tx_o) |-> tcnt >= 3'h4)
    else $error("frame started inside intermission");
  a_eof_recessive: assert property (status_o.tx_done |-> trun >= 4'ha)
    else $error("frame tail not recessive");
endmodule

bind cfa_engine cfa_engine_asserts u_chk (
  .mclk_i          (mclk_i),
  .rst_n_i         (rst_n_i),
  .bit_tick_i      (bit_tick_i),
  .bus_rx_i        (bus_rx_i),
  .bus_tx_o        (bus_tx_o),
  .error_passive_i (error_passive_i),
  .tx_req_i        (tx_req_i),
  .tx_busy_o       (tx_busy_o),
  .status_o        (status_o)
);

// ---- tb/cfa_node_model.sv ----
// Behavioural model of another node sharing the bus line.
`timescale 1ns/1ns
module cfa_node_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        tick_i,
  input  wire logic        bus_i,
  input  wire logic        dut_tx_i,
  input  wire logic        cmp_go_i,
  input  wire logic [10:0] cmp_id_i,
  output logic             node_tx_o
);
  logic [0:127] cap;
  logic [11:0]  cw;
  logic         infr, last, rtr, cbit;
  int           n, run, rrun, h, d, ack;
  // Frame geometry from the header bits caught so far.
  always_comb begin
    cw = {cmp_id_i, 1'b0};
    h = cap[13] ? 39 : 19;
    rtr = cap[13] ? cap[32] : cap[12];
    d = cap[13] ? int'(cap[35:38]) : int'(cap[15:18]);
    ack = h + 16 + (rtr ? 0 : (d > 8 ? 64 : 8 * d));
    cbit = (n > 0 && n < 13) ? cw[12 - n] : 1'b1;
  end
  // Ack slot, competing identifier and a joint start pull the line low.
  assign node_tx_o = !((infr && n == ack && n > h) ||
                       (cmp_go_i && infr && !cbit) ||
                       (cmp_go_i && !infr && !dut_tx_i));
  // Destuff the line and capture frame bits, one per bit tick.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      infr <= 1'b0;
      n    <= 0;
      run  <= 0;
      rrun <= 0;
      last <= 1'b1;
      cap  <= '0;
    end else if (tick_i) begin
      rrun <= bus_i ? rrun + 1 : 0;
      last <= bus_i;
      if (!infr) begin
        infr <= !bus_i;
        n    <= 1;
        run  <= 1;
        if (!bus_i) cap <= '0;
      end else if (bus_i && rrun >= 7) begin
        infr <= 1'b0;
      end else if (run == 5 && (n <= h || n < ack)) begin
        run <= 1;
      end else begin
        cap[n] <= bus_i;
        n      <= n + 1;
        run    <= (bus_i == last) ? run + 1 : 1;
      end
    end
  end
endmodule

// ---- tb/tb_cfa_engine.sv ----
// Self-checking bench of the CAN frame engine.
`timescale 1ns/1ns
`include "cfa_defines.svh"
module tb_cfa_engine;
  import cfa_pkg::*;
  typedef struct packed {
    cfa_msg_s m;
    logic     dup;
  } cfa_row_s;
  logic         mclk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic         tick = 1'b0;
  logic         tx_req = 1'b0;
  logic         cmp_go = 1'b0;
  logic         epass = 1'b0;
  logic         bus_tx, node_tx, busy, rx_valid;
  logic [0:127] eb;
  logic [0:127] msk;
  cfa_msg_s     msg = '0;
  cfa_status_s  st;
  cfa_row_s     rows [5];
  int           err_count = 0;
  int           num_checks = 0;
  int           cyc = 0;
  int           ne;
  cfa_engine u_dut (
    .mclk_i          (mclk_i),
    .rst_n_i         (rst_n_i),
    .bit_tick_i      (tick),
    .bus_rx_i        (bus_tx & node_tx),
    .bus_tx_o        (bus_tx),
    .error_passive_i (epass),
    .tx_req_i        (tx_req),
    .tx_msg_i        (msg),
    .tx_busy_o       (busy),
    .resp_en_i       (1'b0),
    .resp_msg_i      (msg),
    .acc_id_i        (msg.id),
    .acc_mask_i      ('0),
    .acc_ext_i       (1'b0),
    .rx_valid_o      (rx_valid),
    .rx_ready_i      (1'b1),
    .rx_msg_o        (),
    .status_o        (st)
  );
  cfa_node_model u_node (
    .clk_i     (mclk_i),
    .rst_n_i   (rst_n_i),
    .tick_i    (tick),
    .bus_i     (bus_tx & node_tx),
    .dut_tx_i  (bus_tx),
    .cmp_go_i  (cmp_go),
    .cmp_id_i  (11'h554),
    .node_tx_o (node_tx)
  );
  // ==========================================================================
  // Clock, bit ticks every fourth cycle and the run ceiling.
  always #2 mclk_i = ~mclk_i;
  always @(negedge mclk_i) begin
    cyc++;
    tick <= (cyc % 4 == 0);
    if (cyc > 30000) begin
      err_count++;
      conclude();
    end
  end
  // Compares one result and reports a mismatch at once.
  task automatic chk(string nm, logic [127:0] e, logic [127:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  // Appends k bits of v, most significant first, to the expected frame.
  task automatic push(logic [63:0] v, int k);
    for (int i = k - 1; i >= 0; i--) begin
      eb[ne] = v[i];
      ne++;
    end
  endtask
  // Builds the destuffed frame from start bit to the last check bit.
  task automatic build(cfa_msg_s m);
    logic [14:0] c = 15'h0;
    int          nd;
    ne = 0;
    eb = '0;
    nd = m.rtr ? 0 : (m.dlc > 8 ? 64 : 8 * m.dlc);
    push(0, 1);
    push(m.ext ? m.id[28:18] : m.id[10:0], 11);
    if (m.ext) push({2'h3, m.id[17:0]}, 20);
    push({m.rtr, 2'h0, m.dlc}, 7);
    push(m.data >> (64 - nd), nd);
    for (int i = 0; i < ne; i++) begin
      c = {c[13:0], 1'b0} ^ ((eb[i] ^ c[14]) ? `CFA_CRC_POLY : 15'h0);
    end
    push(c, 15);
  endtask
  // Sends one message, waits for its end and checks the bits on the line.
  task automatic send(cfa_msg_s m, logic lose, logic dup);
    logic al = 1'b0;
    logic be = 1'b0;
    msg = m;
    tx_req = 1'b1;
    @(negedge mclk_i);
    tx_req = 1'b0;
    chk("busy", 1, busy);
    if (dup) begin
      msg.id = 29'h0;
      tx_req = 1'b1;
      @(negedge mclk_i);
      tx_req = 1'b0;
    end
    for (int k = 0; k < 4000 && !st.tx_done; k++) begin
      @(negedge mclk_i);
      if (st.arb_lost) al = 1'b1;
      if (st.arb_lost) cmp_go = 1'b0;
      if (st.bus_err) be = 1'b1;
    end
    chk("done", 1, st.tx_done);
    chk("lost", lose, al);
    chk("error", lose, be);
    build(m);
    msk = '1;
    msk = msk << (128 - ne);
    chk("frame", eb, u_node.cap & msk);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Reset, the table of messages, then arbitration against a lower id.
  initial begin
    rows[0] = '{'{1'b0, 1'b0, 29'h0000_0123, 4'h2, 64'hbeef_0000_0000_0000}, 1'b0};
    rows[1] = '{'{1'b1, 1'b0, 29'h1abc_de01, 4'h8, 64'h0123_4567_89ab_cdef}, 1'b1};
    rows[2] = '{'{1'b0, 1'b1, 29'h0000_07f0, 4'h3, 64'h0}, 1'b0};
    rows[3] = '{'{1'b1, 1'b1, 29'h0000_0fff, 4'h0, 64'h0}, 1'b0};
    rows[4] = '{'{1'b0, 1'b0, 29'h0000_0000, 4'h8, 64'hffff_ffff_ffff_ffff}, 1'b0};
    repeat (3) @(negedge mclk_i);
    chk("reset", 8'h80, {bus_tx, busy, rx_valid, st});
    rst_n_i = 1'b1;
    foreach (rows[i]) begin
      send(rows[i].m, 1'b0, rows[i].dup);
    end
    for (int p = 0; p < 2; p++) begin
      epass  = p[0];
      cmp_go = 1'b1;
      send('{1'b0, 1'b0, 29'h0000_0555, 4'h1, 64'h5a00_0000_0000_0000}, 1'b1, 1'b0);
    end
    conclude();
  end
endmodule
